/* File: ct_alarm_pkg.sv */
package ct_alarm_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPEN_TH1_OFS = 8'h04;
  localparam logic [7:0] OPEN_TH2_OFS = 8'h08;
  localparam logic [7:0] SHORT_TH1_OFS = 8'h0C;
  localparam logic [7:0] SHORT_TH2_OFS = 8'h10;
  localparam logic [7:0] HEAT_MON1_OFS = 8'h14;
  localparam logic [7:0] HEAT_MON2_OFS = 8'h18;
  localparam logic [7:0] LEAK_MON1_OFS = 8'h1C;
  localparam logic [7:0] LEAK_MON2_OFS = 8'h20;
  localparam logic [7:0] ALARM_OFS = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h2C;
  localparam logic [7:0] CONFIG_OFS = 8'h30;

  // Control register fields
  localparam int CTRL_OPEN_EN_BIT = 0;
  localparam int CTRL_SHORT_EN_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Currents in units of 0.1 A
  localparam logic [15:0] MON_MAX = 16'h0226;
  localparam logic [15:0] TH_MAX = 16'h01F4;
  localparam logic [15:0] OVER_RANGE = 16'hFFFF;
  localparam logic [15:0] OPEN_TH_RST = 16'h0000;
  localparam logic [15:0] SHORT_TH_RST = 16'h01F4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // Skip windows, in milliseconds
  localparam int OPEN_SKIP_MS = 100;
  localparam int OPEN_SKIP_FAST_MS = 30;
  localparam int SHORT_SKIP_MS = 100;
  localparam int SHORT_SKIP_FAST_MS = 35;
  localparam int MS_COUNT_W = 8;

  // Millisecond tick derived from the 50 MHz clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Monitor value with the over-range code substituted
  function automatic logic [15:0] mon_code(input logic [15:0] cur);
    mon_code = (cur > MON_MAX) ? OVER_RANGE : cur;
  endfunction

endpackage

/* File: ct_channel.sv */
`timescale 1ns/100ps
module ct_channel
  import ct_alarm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic heat_on_i,
  input wire logic on_ok_i,
  input wire logic off_ok_i,
  input wire logic open_en_i,
  input wire logic short_en_i,
  input wire logic [15:0] current_i,
  input wire logic [15:0] open_th_i,
  input wire logic [15:0] short_th_i,
  output logic [15:0] heat_mon_o,
  output logic [15:0] leak_mon_o,
  output logic open_alarm_o,
  output logic short_alarm_o
);

  logic [15:0] heat_mon_r, heat_mon_nxt, leak_mon_r, leak_mon_nxt;
  logic open_r, open_nxt, short_r, short_nxt;

  // Threshold 0 forces off, full scale forces on, else below threshold
  function automatic logic open_judge(input logic [15:0] cur, input logic [15:0] th);
    if (th == 16'h0000)
      open_judge = 1'b0;
    else if (th >= TH_MAX)
      open_judge = 1'b1;
    else
      open_judge = cur < th;
  endfunction

  // Full scale forces off, threshold 0 forces on, else above threshold
  function automatic logic short_judge(input logic [15:0] cur, input logic [15:0] th);
    if (th >= TH_MAX)
      short_judge = 1'b0;
    else if (th == 16'h0000)
      short_judge = 1'b1;
    else
      short_judge = cur > th;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement and judgement; short intervals leave the alarm untouched
  always_comb
  begin
    heat_mon_nxt = heat_mon_r;
    leak_mon_nxt = leak_mon_r;
    open_nxt = open_r;
    short_nxt = short_r;
    if (sample_i && heat_on_i)
    begin
      heat_mon_nxt = mon_code(current_i);
      if (on_ok_i)
        open_nxt = open_judge(current_i, open_th_i);
    end
    if (sample_i && !heat_on_i)
    begin
      leak_mon_nxt = mon_code(current_i);
      if (off_ok_i)
        short_nxt = short_judge(current_i, short_th_i);
    end
    if (!open_en_i)
      open_nxt = 1'b0;
    if (!short_en_i)
      short_nxt = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      heat_mon_r <= 16'h0000;
      leak_mon_r <= 16'h0000;
      open_r <= 1'b0;
      short_r <= 1'b0;
    end
    else
    begin
      heat_mon_r <= heat_mon_nxt;
      leak_mon_r <= leak_mon_nxt;
      open_r <= open_nxt;
      short_r <= short_nxt;
    end
  end

  assign heat_mon_o = heat_mon_r;
  assign leak_mon_o = leak_mon_r;
  assign open_alarm_o = open_r;
  assign short_alarm_o = short_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_over_range;
    sample_i && heat_on_i && current_i > MON_MAX |=> heat_mon_o == OVER_RANGE;
  endproperty
  a_over_range: assert property (p_over_range) else $error("over-range code missing");

  property p_open_hold;
    open_en_i && !(sample_i && heat_on_i && on_ok_i) ##1 open_en_i |-> $stable(open_alarm_o);
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open alarm moved while skipped");

  property p_short_forced_off;
    sample_i && !heat_on_i && off_ok_i && short_th_i == TH_MAX |=> !short_alarm_o;
  endproperty
  a_short_forced_off: assert property (p_short_forced_off) else $error("short not forced off");

  property p_open_low;
    open_en_i && sample_i && heat_on_i && on_ok_i && open_th_i != 16'h0000
      && open_th_i < TH_MAX && current_i < open_th_i ##1 open_en_i |-> open_alarm_o;
  endproperty
  a_open_low: assert property (p_open_low) else $error("open alarm not raised");

endmodule // ct_channel

/* File: heater_current_alarm_monitor.sv */
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module heater_current_alarm_monitor
  import ct_alarm_pkg::*;
#(
  parameter int CT_CHANNELS = 2,
  parameter int TICK_CYCLES = MS_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic heat_on_i,
  input wire logic ct_sample_i,
  input wire logic [15:0] ct1_current_i,
  input wire logic [15:0] ct2_current_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [1:0] heater_open_alarm_o,
  output logic [1:0] relay_short_alarm_o,
  output logic [1:0] flash_heat_o,
  output logic [1:0] flash_leak_o,
  output logic irq_o
);

  localparam int TICK_W = $clog2(TICK_CYCLES);

  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic [MS_COUNT_W-1:0] on_ms_r, on_ms_nxt, off_ms_r, off_ms_nxt;
  logic heat_d_r, heat_d_nxt, tick_ms;
  logic on_ok, off_ok;
  logic [MS_COUNT_W-1:0] open_lim, short_lim;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [15:0] open_th_r [2], open_th_nxt [2], short_th_r [2], short_th_nxt [2];
  logic [15:0] heat_mon [2], leak_mon [2], cur [2];
  logic [1:0] open_al, short_al, open_d_r, short_d_r;
  logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [1:0] flash_heat_r, flash_leak_r;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write, rd_hit;
  logic [31:0] rd_word;
  logic two_ch;

  assign two_ch = (CT_CHANNELS > 1);
  assign cur[0] = ct1_current_i;
  assign cur[1] = ct2_current_i;

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Settings above full scale are pinned to full scale
  function automatic logic [15:0] clamp_th(input logic [15:0] v);
    clamp_th = (v > TH_MAX) ? TH_MAX : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and on/off interval timers
  always_comb
  begin
    tick_ms = (tick_r == TICK_W'(TICK_CYCLES - 1));
    tick_nxt = tick_ms ? '0 : tick_r + 1'b1;
    heat_d_nxt = heat_on_i;
    on_ms_nxt = on_ms_r;
    off_ms_nxt = off_ms_r;
    // A new interval starts from zero on every output edge
    if (heat_on_i != heat_d_r)
    begin
      on_ms_nxt = '0;
      off_ms_nxt = '0;
    end
    else if (tick_ms && heat_on_i && on_ms_r != '1)
      on_ms_nxt = on_ms_r + 1'b1;
    else if (tick_ms && !heat_on_i && off_ms_r != '1)
      off_ms_nxt = off_ms_r + 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      tick_r <= '0;
      on_ms_r <= '0;
      off_ms_r <= '0;
      heat_d_r <= 1'b0;
    end
    else
    begin
      tick_r <= tick_nxt;
      on_ms_r <= on_ms_nxt;
      off_ms_r <= off_ms_nxt;
      heat_d_r <= heat_d_nxt;
    end
  end

  // Detection only once the interval has outlived its skip window
  assign open_lim = ctrl_r[CTRL_FAST_BIT] ? MS_COUNT_W'(OPEN_SKIP_FAST_MS)
                                          : MS_COUNT_W'(OPEN_SKIP_MS);
  assign short_lim = ctrl_r[CTRL_FAST_BIT] ? MS_COUNT_W'(SHORT_SKIP_FAST_MS)
                                           : MS_COUNT_W'(SHORT_SKIP_MS);
  assign on_ok = heat_on_i && heat_d_r && (on_ms_r > open_lim);
  assign off_ok = !heat_on_i && !heat_d_r && (off_ms_r > short_lim);

  ////////////////////////////////////////////////////////////////////////////////
  // Channels; an unfitted second channel reads and alarms as zero
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    if (c < CT_CHANNELS)
    begin : g_fit
      ct_channel u_ch (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sample_i(ct_sample_i),
        .heat_on_i(heat_on_i),
        .on_ok_i(on_ok),
        .off_ok_i(off_ok),
        .open_en_i(ctrl_r[CTRL_OPEN_EN_BIT]),
        .short_en_i(ctrl_r[CTRL_SHORT_EN_BIT]),
        .current_i(cur[c]),
        .open_th_i(open_th_r[c]),
        .short_th_i(short_th_r[c]),
        .heat_mon_o(heat_mon[c]),
        .leak_mon_o(leak_mon[c]),
        .open_alarm_o(open_al[c]),
        .short_alarm_o(short_al[c])
      );
    end
    else
    begin : g_absent
      assign heat_mon[c] = 16'h0000;
      assign leak_mon[c] = 16'h0000;
      assign open_al[c] = 1'b0;
      assign short_al[c] = 1'b0;
    end
  end

  assign heater_open_alarm_o = open_al;
  assign relay_short_alarm_o = short_al;

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode; disabled or absent items read as zero
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      CTRL_OFS: rd_word = {29'h0, ctrl_r};
      OPEN_TH1_OFS: rd_word = ctrl_r[CTRL_OPEN_EN_BIT] ? {16'h0, open_th_r[0]} : '0;
      OPEN_TH2_OFS: rd_word = (ctrl_r[CTRL_OPEN_EN_BIT] && two_ch) ? {16'h0, open_th_r[1]} : '0;
      SHORT_TH1_OFS: rd_word = ctrl_r[CTRL_SHORT_EN_BIT] ? {16'h0, short_th_r[0]} : '0;
      SHORT_TH2_OFS: rd_word = (ctrl_r[CTRL_SHORT_EN_BIT] && two_ch) ? {16'h0, short_th_r[1]}
                                                                     : '0;
      HEAT_MON1_OFS: rd_word = ctrl_r[CTRL_OPEN_EN_BIT] ? {16'h0, heat_mon[0]} : '0;
      HEAT_MON2_OFS: rd_word = ctrl_r[CTRL_OPEN_EN_BIT] ? {16'h0, heat_mon[1]} : '0;
      LEAK_MON1_OFS: rd_word = ctrl_r[CTRL_SHORT_EN_BIT] ? {16'h0, leak_mon[0]} : '0;
      LEAK_MON2_OFS: rd_word = ctrl_r[CTRL_SHORT_EN_BIT] ? {16'h0, leak_mon[1]} : '0;
      ALARM_OFS: rd_word = {28'h0, short_al, open_al};
      IRQ_STAT_OFS: rd_word = {28'h0, stat_r};
      IRQ_MASK_OFS: rd_word = {28'h0, mask_r};
      CONFIG_OFS: rd_word = {31'h0, two_ch};
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite channels; address and data may arrive in either order
  always_comb
  begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    do_write = aw_full_r && w_full_r && !bvalid_r;
    if (s_axi_awvalid_i && awready_r)
    begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_r)
    begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata_i;
      w_strb_nxt = s_axi_wstrb_i;
    end
    if (do_write)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (aw_addr_r[1:0] != 2'h0 || aw_addr_r > CONFIG_OFS)
        bresp_nxt = RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready_i)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid_i && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
      rvalid_nxt = 1'b0;
    // Ready flags are registered so every bus output leaves a flop
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings, sticky events, interrupt and flash requests
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    open_th_nxt = open_th_r;
    short_th_nxt = short_th_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (do_write)
    begin
      unique case (aw_addr_r)
        CTRL_OFS: if (w_strb_r[0]) ctrl_nxt = w_data_r[2:0];
        OPEN_TH1_OFS: if (ctrl_r[CTRL_OPEN_EN_BIT])
          open_th_nxt[0] = clamp_th(merge16(open_th_r[0], w_data_r, w_strb_r));
        OPEN_TH2_OFS: if (ctrl_r[CTRL_OPEN_EN_BIT] && two_ch)
          open_th_nxt[1] = clamp_th(merge16(open_th_r[1], w_data_r, w_strb_r));
        SHORT_TH1_OFS: if (ctrl_r[CTRL_SHORT_EN_BIT])
          short_th_nxt[0] = clamp_th(merge16(short_th_r[0], w_data_r, w_strb_r));
        SHORT_TH2_OFS: if (ctrl_r[CTRL_SHORT_EN_BIT] && two_ch)
          short_th_nxt[1] = clamp_th(merge16(short_th_r[1], w_data_r, w_strb_r));
        IRQ_STAT_OFS: if (w_strb_r[0]) stat_nxt = stat_r & ~w_data_r[3:0];
        IRQ_MASK_OFS: if (w_strb_r[0]) mask_nxt = w_data_r[3:0];
        default: ;
      endcase
    end
    // New alarms set after the clear so an event in the clear cycle survives
    stat_nxt = stat_nxt | {short_al & ~short_d_r, open_al & ~open_d_r};
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= CTRL_RST;
      open_th_r <= '{OPEN_TH_RST, OPEN_TH_RST};
      short_th_r <= '{SHORT_TH_RST, SHORT_TH_RST};
      mask_r <= IRQ_MASK_RST;
      stat_r <= 4'h0;
      irq_r <= 1'b0;
      open_d_r <= 2'h0;
      short_d_r <= 2'h0;
      flash_heat_r <= 2'h0;
      flash_leak_r <= 2'h0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      open_th_r <= open_th_nxt;
      short_th_r <= short_th_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      open_d_r <= open_al;
      short_d_r <= short_al;
      flash_heat_r <= open_al;
      flash_leak_r <= short_al;
    end
  end

  assign flash_heat_o = flash_heat_r;
  assign flash_leak_o = flash_leak_r;
  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Watches the alarm itself, so a broken skip window cannot hide behind on_ok
  property p_open_skip;
    ctrl_r[CTRL_OPEN_EN_BIT] && heat_on_i && on_ms_r <= open_lim
      ##1 ctrl_r[CTRL_OPEN_EN_BIT] |-> $stable(open_al);
  endproperty
  a_open_skip: assert property (p_open_skip) else $error("open check inside skip window");

  property p_short_skip;
    ctrl_r[CTRL_SHORT_EN_BIT] && !heat_on_i && off_ms_r <= short_lim
      ##1 ctrl_r[CTRL_SHORT_EN_BIT] |-> $stable(short_al);
  endproperty
  a_short_skip: assert property (p_short_skip) else $error("short check inside skip window");

  property p_flash_heat;
    open_al[0] |=> flash_heat_o[0];
  endproperty
  a_flash_heat: assert property (p_flash_heat) else $error("heat flash missing");

  property p_flash_leak;
    short_al[0] ##1 short_al[0] |-> flash_leak_o[0];
  endproperty
  a_flash_leak: assert property (p_flash_leak) else $error("leak flash missing");

  property p_irq_follow;
    irq_o == ((stat_r & mask_r) != 4'h0);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not raised");

  property p_second_absent;
    CT_CHANNELS < 2 |-> open_al[1] == 1'b0 && short_al[1] == 1'b0;
  endproperty
  a_second_absent: assert property (p_second_absent) else $error("absent channel alarms");

endmodule // heater_current_alarm_monitor

/* File: ct_sensor_model.sv */
`timescale 1ns/100ps
module ct_sensor_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic heat_on_i,
  input wire logic [15:0] heat1_i,
  input wire logic [15:0] heat2_i,
  input wire logic [15:0] leak1_i,
  input wire logic [15:0] leak2_i,
  output logic sample_o,
  output logic [15:0] ct1_o,
  output logic [15:0] ct2_o
);
  logic [2:0] div_r;
  ////////////////////////////////////////////////
  // One reading every eight cycles; between readings the lines toggle,
  // so a design that samples off the strobe picks up garbage
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      div_r <= 3'h0;
      sample_o <= 1'h0;
      ct1_o <= 16'h0;
      ct2_o <= 16'h0;
    end
    else
    begin
      div_r <= div_r + 3'h1;
      sample_o <= (div_r == 3'h7);
      ct1_o <= (div_r == 3'h7) ? (heat_on_i ? heat1_i : leak1_i) : ~ct1_o;
      ct2_o <= (div_r == 3'h7) ? (heat_on_i ? heat2_i : leak2_i) : ~ct2_o;
    end
  end
endmodule // ct_sensor_model

/* File: heater_current_alarm_monitor_test.sv */
`timescale 1ns/100ps
module heater_current_alarm_monitor_test;
  import ct_alarm_pkg::*;
  // Ten cycles per ms keeps the 100 ms windows short
  localparam int TICK = 10;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic heat_on = 1'h0;
  logic [15:0] h1 = 16'h0, h2 = 16'h0, l1 = 16'h0, l2 = 16'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, smp, irq;
  logic [1:0] bresp, rresp, rrsp, open_al, short_al, fl_h, fl_l;
  logic [31:0] rdata, rdat;
  logic [15:0] ct1, ct2;
  int failures = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  ct_sensor_model sensor (.mclk_i(clk), .rst_n_i(rst_n), .heat_on_i(heat_on),
    .heat1_i(h1), .heat2_i(h2), .leak1_i(l1), .leak2_i(l2),
    .sample_o(smp), .ct1_o(ct1), .ct2_o(ct2));

  heater_current_alarm_monitor #(.CT_CHANNELS(2), .TICK_CYCLES(TICK)) dut (
    .mclk_i(clk), .rst_n_i(rst_n), .heat_on_i(heat_on), .ct_sample_i(smp),
    .ct1_current_i(ct1), .ct2_current_i(ct2),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .heater_open_alarm_o(open_al), .relay_short_alarm_o(short_al),
    .flash_heat_o(fl_h), .flash_leak_o(fl_l), .irq_o(irq));
  ////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write; address and data released separately as each is taken
  // Only the watchdog ends a wait for the response
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask

  // Read; data and response taken at the edge that sees rvalid
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'h0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask

  // Hold one heater state and set of currents for a number of ms
  task run(input logic on, input logic [15:0] a, b, c, e, input int ms);
    @(posedge clk);
    heat_on <= on;
    h1 <= a;
    h2 <= b;
    l1 <= c;
    l2 <= e;
    repeat (ms * TICK + 4) @(posedge clk);
  endtask

  task final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////
  // Watchdog, well past the roughly 6900 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    rdc(OPEN_TH1_OFS, 32'h0);
    rdc(SHORT_TH1_OFS, 32'h0);
    rdc(CONFIG_OFS, 32'h1);
    rdc(HEAT_MON1_OFS, 32'h0);
    rd(8'h34);
    chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
    // Thresholds only read back once their detection is enabled
    wr(CTRL_OFS, 32'h3);
    rdc(OPEN_TH1_OFS, 32'h0);
    rdc(SHORT_TH1_OFS, 32'h1F4);
    $display("test reset_values done");
    wr(OPEN_TH1_OFS, 32'hC8);
    wr(OPEN_TH2_OFS, 32'hC8);
    wr(SHORT_TH1_OFS, 32'h32);
    wr(IRQ_MASK_OFS, 32'h1);
    run(1'h1, 16'h64, 16'h12C, 16'h0, 16'h0, 120);
    chk({30'h0, open_al}, 32'h1);
    chk({30'h0, fl_h}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(HEAT_MON1_OFS, 32'h64);
    rdc(HEAT_MON2_OFS, 32'h12C);
    wr(IRQ_STAT_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    run(1'h1, 16'h258, 16'h12C, 16'h0, 16'h0, 20);
    rdc(HEAT_MON1_OFS, 32'hFFFF);
    chk({30'h0, open_al}, 32'h0);
    $display("test open_alarm done");
    run(1'h0, 16'h0, 16'h0, 16'h0, 16'h0, 120);
    run(1'h1, 16'h0, 16'h12C, 16'h0, 16'h0, 50);
    chk({30'h0, open_al}, 32'h0);
    run(1'h0, 16'h0, 16'h0, 16'h64, 16'h0, 120);
    chk({30'h0, short_al}, 32'h1);
    chk({30'h0, fl_l}, 32'h1);
    chk({30'h0, open_al}, 32'h0);
    rdc(LEAK_MON1_OFS, 32'h64);
    run(1'h1, 16'h12C, 16'h12C, 16'h0, 16'h0, 120);
    run(1'h0, 16'h0, 16'h0, 16'h0, 16'h0, 50);
    chk({30'h0, short_al}, 32'h1);
    $display("test short_alarm done");
    wr(CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk({28'h0, short_al, open_al}, 32'h0);
    rdc(LEAK_MON1_OFS, 32'h0);
    $display("test disable done");
    // Fast control period: 30 ms on and 35 ms off skip windows
    wr(CTRL_OFS, 32'h7);
    run(1'h1, 16'h0, 16'h12C, 16'h0, 16'h0, 40);
    chk({30'h0, open_al}, 32'h1);
    run(1'h0, 16'h0, 16'h0, 16'h64, 16'h0, 20);
    chk({30'h0, short_al}, 32'h0);
    run(1'h0, 16'h0, 16'h0, 16'h64, 16'h0, 20);
    chk({30'h0, short_al}, 32'h1);
    $display("test fast_period done");
    final_report;
  end
endmodule // heater_current_alarm_monitor_test
